// ==== src/dsc_regs.v ====
// sink configuration and status register bank on an axi4-lite slave
`timescale 1ns/1ps
`include "dsc_map.vh"
module dsc_regs #(
  parameter ADDR_W = 8,
  parameter HPD_LOW_CYCLES = `DSC_HPD_LOW_US * `DSC_CLK_MHZ
) (
  input wire core_clk_in,
  input wire rst_b_in,
  input wire [ADDR_W-1:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output reg s_axi_awready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output reg s_axi_wready_out,
  output reg [1:0] s_axi_bresp_out,
  output reg s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire [ADDR_W-1:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output reg s_axi_arready_out,
  output reg [31:0] s_axi_rdata_out,
  output reg [1:0] s_axi_rresp_out,
  output reg s_axi_rvalid_out,
  input wire s_axi_rready_in,
  input wire [2:0] lane_count_in,
  input wire ev_ext_pkt_in,
  input wire ev_info_pkt_in,
  input wire ev_power_state_in,
  input wire scrambler_reset_in,
  input wire frame_start_in,
  input wire training_done_in,
  input wire link_locked_in,
  input wire vbid_vblank_in,
  input wire vbid_novideo_in,
  input wire active_video_in,
  input wire msa_valid_in,
  input wire [15:0] msa_hres_in,
  input wire [15:0] msa_vres_in,
  input wire aux_in_progress_in,
  input wire aux_sync_in,
  input wire aux_edge_in,
  input wire aux_req_done_in,
  input wire aux_req_err_in,
  input wire [3:0] aux_cmd_in,
  input wire [19:0] aux_addr_in,
  input wire [3:0] aux_len_in,
  input wire aux_addr_only_in,
  input wire active_end_in,
  output reg hpd_out,
  output reg aux_tick_out,
  output reg timing_gen_en_out,
  output reg [2:0] pixel_width_out,
  output reg msa_filter_on_out,
  output reg i2c_defer_long_out,
  output reg i2c_defer_as_aux_out,
  output reg video_rst_out,
  output reg [15:0] msa_hres_out,
  output reg [15:0] msa_vres_out,
  output reg hsync_out,
  output reg [7:0] fast_i2c_div_out,
  output reg irq_out
);

  localparam [2:0] HS_IDLE = 3'b001;
  localparam [2:0] HS_PORCH = 3'b010;
  localparam [2:0] HS_PULSE = 3'b100;

  // byte-lane merge of a write into a stored word
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1)
        wmerge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  reg rx_en_q;
  reg [7:0] aux_div_q;
  reg tg_en_q;
  reg [2:0] pix_w_q;
  reg pix_ovr_q;
  reg [9:0] mask_q;
  reg [2:0] ctrl_q;
  reg [7:0] err_cnt_q;
  reg [7:0] req_cnt_q;
  reg [9:0] sync_per_q;
  reg [9:0] sync_cnt_q;
  reg sync_seen_q;
  reg [3:0] cmd_q;
  reg [19:0] addr_q;
  reg [3:0] len_q;
  reg [9:0] cause_q;
  reg [9:0] cause_d;
  reg [15:0] hsync_q;
  reg [7:0] fast_div_q;
  reg [7:0] div_cnt_q;
  reg [31:0] hpd_cnt_q;
  reg [3:0] frame_cnt_q;
  reg vid_wait_q;
  reg trained_q;
  reg locked_q;
  reg vblank_q;
  reg novid_q;
  reg vid_seen_q;
  reg [15:0] hres_prev_q;
  reg [15:0] vres_prev_q;
  reg [2:0] hs_state_q;
  reg [7:0] hs_cnt_q;
  reg [31:0] rdata_d;
  reg rmapped_d;
  reg wmapped_d;

  // write accepted when address and data are both present
  wire wr_go = s_axi_awvalid_in && s_axi_wvalid_in && !s_axi_bvalid_out
               && !s_axi_awready_out;
  wire rd_go = s_axi_arvalid_in && !s_axi_rvalid_out && !s_axi_arready_out;
  wire [ADDR_W-1:0] waddr = s_axi_awaddr_in;
  wire [31:0] wd = wmerge(32'h0, s_axi_wdata_in, s_axi_wstrb_in);
  wire wr_cause_rd = rd_go && (s_axi_araddr_in == `DSC_OFF_CAUSE);
  wire [31:0] mask_wm = wmerge({22'h0, mask_q}, s_axi_wdata_in, s_axi_wstrb_in);
  wire [31:0] hsync_wm = wmerge({16'h0, hsync_q}, s_axi_wdata_in, s_axi_wstrb_in);

  // cause events
  wire lost_ev = trained_q && locked_q && !link_locked_in;
  wire vblank_ev = vbid_vblank_in && !vblank_q;
  wire novid_ev = vbid_novideo_in && !novid_q && vid_seen_q;
  wire video_ev = vid_wait_q && frame_start_in
                  && (frame_cnt_q == `DSC_VIDEO_FRAMES - 4'h1);
  wire msa_upd = msa_valid_in && (!ctrl_q[`DSC_CTRL_MSA_FILT]
                 || (msa_hres_in == hres_prev_q && msa_vres_in == vres_prev_q));
  wire mode_ev = msa_upd && (msa_hres_in != msa_hres_out
                 || msa_vres_in != msa_vres_out);
  wire [9:0] events = {ev_ext_pkt_in, ev_info_pkt_in, 1'b0, video_ev, 1'b0,
                       lost_ev, vblank_ev, novid_ev, ev_power_state_in, mode_ev};

  // cause register update, set wins over read-clear
  always @*
  begin
    cause_d = wr_cause_rd ? 10'h000 : cause_q;
    cause_d = cause_d | events;
  end

  // read mux
  always @*
  begin
    rdata_d = 32'h0;
    rmapped_d = 1'b1;
    case (s_axi_araddr_in)
      `DSC_OFF_RX_EN: rdata_d[0] = rx_en_q;
      `DSC_OFF_AUX_DIV: rdata_d[7:0] = aux_div_q;
      `DSC_OFF_TG_EN: rdata_d[0] = tg_en_q;
      `DSC_OFF_PIX_W: rdata_d[2:0] = pix_w_q;
      `DSC_OFF_IRQ_MASK: rdata_d[9:0] = mask_q;
      `DSC_OFF_CTRL: rdata_d[2:0] = ctrl_q;
      `DSC_OFF_SOFT_RST: rdata_d = 32'h0;
      `DSC_OFF_AUX_PEND: rdata_d[0] = aux_in_progress_in;
      `DSC_OFF_ERR_CNT: rdata_d[7:0] = err_cnt_q;
      `DSC_OFF_REQ_CNT: rdata_d[7:0] = req_cnt_q;
      `DSC_OFF_HPD_IRQ: rdata_d = 32'h0;
      `DSC_OFF_SYNC_PER: rdata_d[9:0] = sync_per_q;
      `DSC_OFF_CMD: rdata_d[3:0] = cmd_q;
      `DSC_OFF_ADDR: rdata_d[19:0] = addr_q;
      `DSC_OFF_LEN: rdata_d[3:0] = len_q;
      `DSC_OFF_CAUSE: rdata_d[9:0] = cause_q;
      `DSC_OFF_HSYNC: rdata_d[15:0] = hsync_q;
      `DSC_OFF_FAST_I2C: rdata_d[7:0] = fast_div_q;
      default: rmapped_d = 1'b0;
    endcase
  end

  always @*
  begin
    wmapped_d = 1'b1;
    case (waddr)
      `DSC_OFF_RX_EN, `DSC_OFF_AUX_DIV, `DSC_OFF_TG_EN, `DSC_OFF_PIX_W,
      `DSC_OFF_IRQ_MASK, `DSC_OFF_CTRL, `DSC_OFF_SOFT_RST, `DSC_OFF_AUX_PEND,
      `DSC_OFF_ERR_CNT, `DSC_OFF_REQ_CNT, `DSC_OFF_HPD_IRQ, `DSC_OFF_SYNC_PER,
      `DSC_OFF_CMD, `DSC_OFF_ADDR, `DSC_OFF_LEN, `DSC_OFF_CAUSE,
      `DSC_OFF_HSYNC, `DSC_OFF_FAST_I2C: wmapped_d = 1'b1;
      default: wmapped_d = 1'b0;
    endcase
  end

  // bus handshake
  always @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `DSC_RESP_OKAY;
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rresp_out <= `DSC_RESP_OKAY;
      s_axi_rdata_out <= 32'h0;
    end
    else
    begin
      s_axi_awready_out <= wr_go;
      s_axi_wready_out <= wr_go;
      if (wr_go)
      begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= wmapped_d ? `DSC_RESP_OKAY : `DSC_RESP_DECERR;
      end
      else if (s_axi_bready_in)
        s_axi_bvalid_out <= 1'b0;
      s_axi_arready_out <= rd_go;
      if (rd_go)
      begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out <= rdata_d;
        s_axi_rresp_out <= rmapped_d ? `DSC_RESP_OKAY : `DSC_RESP_DECERR;
      end
      else if (s_axi_rready_in)
        s_axi_rvalid_out <= 1'b0;
    end
  end

  // software registers
  always @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rx_en_q <= 1'b0;
      aux_div_q <= `DSC_AUX_DIV_RST;
      tg_en_q <= 1'b0;
      pix_w_q <= 3'h1;
      pix_ovr_q <= 1'b0;
      mask_q <= `DSC_MASK_RST;
      ctrl_q <= 3'h0;
      hsync_q <= `DSC_HSYNC_RST;
      fast_div_q <= 8'h0;
      video_rst_out <= 1'b0;
    end
    else
    begin
      video_rst_out <= wr_go && waddr == `DSC_OFF_SOFT_RST
                       && s_axi_wstrb_in[0] && s_axi_wdata_in[0];
      if (!pix_ovr_q)
        pix_w_q <= lane_count_in;
      if (wr_go)
      begin
        case (waddr)
          `DSC_OFF_RX_EN: rx_en_q <= s_axi_wstrb_in[0] ? wd[0] : rx_en_q;
          `DSC_OFF_AUX_DIV: aux_div_q <= s_axi_wstrb_in[0] ? wd[7:0] : aux_div_q;
          `DSC_OFF_TG_EN: tg_en_q <= s_axi_wstrb_in[0] ? wd[0] : tg_en_q;
          `DSC_OFF_PIX_W:
          begin
            pix_w_q <= s_axi_wstrb_in[0] ? wd[2:0] : pix_w_q;
            pix_ovr_q <= pix_ovr_q | s_axi_wstrb_in[0];
          end
          `DSC_OFF_IRQ_MASK:
            mask_q <= mask_wm[9:0];
          `DSC_OFF_CTRL: ctrl_q <= s_axi_wstrb_in[0] ? wd[2:0] : ctrl_q;
          `DSC_OFF_HSYNC: hsync_q <= hsync_wm[15:0];
          `DSC_OFF_FAST_I2C: fast_div_q <= s_axi_wstrb_in[0] ? wd[7:0] : fast_div_q;
          default: ;
        endcase
      end
    end
  end

  // aux request capture and counters
  always @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      err_cnt_q <= 8'h0;
      req_cnt_q <= 8'h0;
      cmd_q <= 4'h0;
      addr_q <= 20'h0;
      len_q <= 4'h0;
      sync_per_q <= 10'h0;
      sync_cnt_q <= 10'h0;
      sync_seen_q <= 1'b0;
    end
    else
    begin
      if (wr_go && waddr == `DSC_OFF_REQ_CNT)
      begin
        req_cnt_q <= {7'h0, aux_req_done_in};
        err_cnt_q <= {7'h0, aux_req_err_in};
      end
      else
      begin
        req_cnt_q <= req_cnt_q + {7'h0, aux_req_done_in};
        err_cnt_q <= err_cnt_q + {7'h0, aux_req_err_in};
      end
      if (aux_req_done_in)
      begin
        cmd_q <= aux_cmd_in;
        addr_q <= aux_cmd_in[3] ? aux_addr_in : {13'h0, aux_addr_in[6:0]};
        len_q <= aux_addr_only_in ? 4'h0 : aux_len_in;
      end
      // cycles between successive sync rising edges
      if (!aux_sync_in)
        sync_seen_q <= 1'b0;
      else if (aux_edge_in)
      begin
        if (sync_seen_q)
          sync_per_q <= sync_cnt_q;
        sync_seen_q <= 1'b1;
        sync_cnt_q <= 10'h1;
      end
      else
        sync_cnt_q <= sync_cnt_q + 10'h1;
    end
  end

  // event tracking, cause and interrupt
  always @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cause_q <= 10'h0;
      irq_out <= 1'b0;
      frame_cnt_q <= 4'h0;
      vid_wait_q <= 1'b0;
      trained_q <= 1'b0;
      locked_q <= 1'b0;
      vblank_q <= 1'b0;
      novid_q <= 1'b0;
      vid_seen_q <= 1'b0;
      hres_prev_q <= 16'h0;
      vres_prev_q <= 16'h0;
      msa_hres_out <= 16'h0;
      msa_vres_out <= 16'h0;
    end
    else
    begin
      cause_q <= cause_d;
      irq_out <= |(cause_d & ~mask_q);
      trained_q <= training_done_in;
      locked_q <= link_locked_in;
      vblank_q <= vbid_vblank_in;
      novid_q <= vbid_novideo_in;
      if (novid_ev)
        vid_seen_q <= 1'b0;
      else if (active_video_in)
        vid_seen_q <= 1'b1;
      if (scrambler_reset_in)
      begin
        vid_wait_q <= 1'b1;
        frame_cnt_q <= 4'h0;
      end
      else if (vid_wait_q && frame_start_in)
      begin
        frame_cnt_q <= frame_cnt_q + 4'h1;
        if (video_ev)
          vid_wait_q <= 1'b0;
      end
      if (msa_valid_in)
      begin
        hres_prev_q <= msa_hres_in;
        vres_prev_q <= msa_vres_in;
      end
      if (msa_upd)
      begin
        msa_hres_out <= msa_hres_in;
        msa_vres_out <= msa_vres_in;
      end
    end
  end

  // aux tick, hot-plug, hsync and control outputs
  always @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      div_cnt_q <= 8'h0;
      aux_tick_out <= 1'b0;
      hpd_cnt_q <= 32'h0;
      hpd_out <= 1'b0;
      hs_state_q <= HS_IDLE;
      hs_cnt_q <= 8'h0;
      hsync_out <= 1'b0;
      timing_gen_en_out <= 1'b0;
      pixel_width_out <= 3'h1;
      msa_filter_on_out <= 1'b0;
      i2c_defer_long_out <= 1'b0;
      i2c_defer_as_aux_out <= 1'b0;
      fast_i2c_div_out <= 8'h0;
    end
    else
    begin
      if (div_cnt_q + 8'h1 >= aux_div_q)
      begin
        div_cnt_q <= 8'h0;
        aux_tick_out <= 1'b1;
      end
      else
      begin
        div_cnt_q <= div_cnt_q + 8'h1;
        aux_tick_out <= 1'b0;
      end
      if (wr_go && waddr == `DSC_OFF_HPD_IRQ && s_axi_wstrb_in[0] && s_axi_wdata_in[0])
        hpd_cnt_q <= HPD_LOW_CYCLES;
      else if (hpd_cnt_q != 32'h0)
        hpd_cnt_q <= hpd_cnt_q - 32'h1;
      hpd_out <= rx_en_q && (hpd_cnt_q == 32'h0);
      timing_gen_en_out <= tg_en_q;
      pixel_width_out <= pix_w_q;
      msa_filter_on_out <= ctrl_q[`DSC_CTRL_MSA_FILT];
      i2c_defer_long_out <= ctrl_q[`DSC_CTRL_I2C_DEFER];
      i2c_defer_as_aux_out <= ctrl_q[`DSC_CTRL_AUX_DEFER];
      fast_i2c_div_out <= fast_div_q;
      case (hs_state_q)
        HS_IDLE:
        begin
          hsync_out <= 1'b0;
          if (tg_en_q && active_end_in)
          begin
            hs_state_q <= HS_PORCH;
            hs_cnt_q <= hsync_q[15:8];
          end
        end
        HS_PORCH:
        begin
          if (hs_cnt_q == 8'h0 || hs_cnt_q == 8'h1)
          begin
            hs_state_q <= HS_PULSE;
            hsync_out <= hsync_q[7:0] != 8'h0;
            hs_cnt_q <= hsync_q[7:0];
          end
          else
            hs_cnt_q <= hs_cnt_q - 8'h1;
        end
        HS_PULSE:
        begin
          if (hs_cnt_q == 8'h0 || hs_cnt_q == 8'h1)
          begin
            hs_state_q <= HS_IDLE;
            hsync_out <= 1'b0;
          end
          else
            hs_cnt_q <= hs_cnt_q - 8'h1;
        end
        default:
        begin
          hs_state_q <= HS_IDLE;
          hsync_out <= 1'b0;
        end
      endcase
      if (!tg_en_q)
      begin
        hs_state_q <= HS_IDLE;
        hsync_out <= 1'b0;
      end
    end
  end

endmodule // dsc_regs

// ==== src/dsc_map.vh ====
// register map, field positions, reset values and timing for the sink register bank
// Behaviour
// - unlisted register bits are reserved and read back as zero.
// - receiver enable bit 0 enables receiver and drives hot-plug detect high.
// - 8-bit integer divider makes 1 MHz aux tick from host clock.
// - timing-generator enable bit 0 turns generator on; software clears on no-video.
// - pixel width follows lane count until host writes; codes 1, 2, 4.
// - mask bit set blocks its cause from host interrupt; mask resets to ones.
// - valid-video cause only after eight frames following scrambler reset.
// - reading cause register returns pending bits and clears all at once.
// - cause bits 9,8,6,4,3,2,1,0 as extension, info, video, lost, vblank, novideo, power, mode.
// - training-lost set only when trained receiver loses lock.
// - vblank cause set at start of each vertical blanking from VB-ID.
// - no-video cause set when no-video flags follow received active video.
// - msa filter on needs two matching values before update; off passes through.
// - control bit 1 defers long i2c writes; bit 2 sends i2c defer as aux defer.
// - write one to soft reset bit 0 resets video logic; reads zero.
// - two 8-bit counters for aux requests and errors; write to 0x28 clears both.
// - hot-plug pulse write drives hot-plug detect low 750 us; reads zero.
// - record 10-bit cycle count between rising edges during aux sync.
// - capture 4-bit command and 20-bit address; i2c keeps seven low bits.
// - captured length is byte count minus one; zero for address-only.
// - hsync high for bits 7:0 cycles after porch bits 15:8; reset 0x0f0f.
`ifndef DSC_MAP_VH
`define DSC_MAP_VH
`define DSC_OFF_RX_EN 8'h00
`define DSC_OFF_AUX_DIV 8'h04
`define DSC_OFF_TG_EN 8'h0c
`define DSC_OFF_PIX_W 8'h10
`define DSC_OFF_IRQ_MASK 8'h14
`define DSC_OFF_CTRL 8'h18
`define DSC_OFF_SOFT_RST 8'h1c
`define DSC_OFF_AUX_PEND 8'h20
`define DSC_OFF_ERR_CNT 8'h24
`define DSC_OFF_REQ_CNT 8'h28
`define DSC_OFF_HPD_IRQ 8'h2c
`define DSC_OFF_SYNC_PER 8'h30
`define DSC_OFF_CMD 8'h34
`define DSC_OFF_ADDR 8'h38
`define DSC_OFF_LEN 8'h3c
`define DSC_OFF_CAUSE 8'h40
`define DSC_OFF_HSYNC 8'h50
`define DSC_OFF_FAST_I2C 8'h60
`define DSC_CAUSE_MODE 0
`define DSC_CAUSE_POWER 1
`define DSC_CAUSE_NOVID 2
`define DSC_CAUSE_VBLANK 3
`define DSC_CAUSE_LOST 4
`define DSC_CAUSE_VIDEO 6
`define DSC_CAUSE_INFO 8
`define DSC_CAUSE_EXT 9
`define DSC_CTRL_MSA_FILT 0
`define DSC_CTRL_I2C_DEFER 1
`define DSC_CTRL_AUX_DEFER 2
`define DSC_MASK_RST 10'h3ff
`define DSC_HSYNC_RST 16'h0f0f
`define DSC_AUX_DIV_RST 8'h14
`define DSC_VIDEO_FRAMES 4'h8
`define DSC_CLK_MHZ 20
`define DSC_HPD_LOW_US 750
`define DSC_RESP_OKAY 2'b00
`define DSC_RESP_DECERR 2'b11
`endif

// ==== test/dsc_regs_asserts.sv ====
// concurrent checks on the sink register bank ports
`timescale 1ns/1ps
module dsc_regs_asserts #(
  parameter ADDR_W = 8,
  parameter HPD_LOW_CYCLES = 20
) (
  input wire core_clk_in,
  input wire rst_b_in,
  input wire [ADDR_W-1:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  input wire [31:0] s_axi_wdata_in,
  input wire s_axi_wvalid_in,
  input wire s_axi_awready_out,
  input wire s_axi_wready_out,
  input wire s_axi_bvalid_out,
  input wire [ADDR_W-1:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  input wire s_axi_arready_out,
  input wire [31:0] s_axi_rdata_out,
  input wire [1:0] s_axi_rresp_out,
  input wire s_axi_rvalid_out,
  input wire s_axi_rready_in,
  input wire video_rst_out,
  input wire hpd_out,
  input wire irq_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  sequence wr_take;
    s_axi_awvalid_in && s_axi_wvalid_in && !s_axi_bvalid_out && !s_axi_awready_out;
  endsequence
  sequence rd_take;
    s_axi_arvalid_in && !s_axi_rvalid_out && !s_axi_arready_out;
  endsequence
  a_write_answer: assert property (wr_take |=> s_axi_awready_out && s_axi_bvalid_out)
    else $error("write not answered next cycle");
  a_read_answer: assert property (rd_take |=> s_axi_arready_out && s_axi_rvalid_out)
    else $error("read not answered next cycle");
  a_ready_pulse: assert property (s_axi_awready_out |-> s_axi_wready_out ##1 !s_axi_awready_out)
    else $error("write ready not a paired pulse");
  a_rvalid_drop: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
    else $error("read valid held after accept");
  a_wo_reads_zero: assert property ((rd_take and (s_axi_araddr_in == 8'h1c ||
    s_axi_araddr_in == 8'h2c)) |=> s_axi_rdata_out == 0 && s_axi_rresp_out == 2'b00)
    else $error("write-only register read nonzero");
  a_unmapped_decerr: assert property ((rd_take and s_axi_araddr_in == 8'h08) |=>
    s_axi_rresp_out == 2'b11 && s_axi_rdata_out == 0)
    else $error("unmapped read not zero with error");
  a_hpd_pulse_low: assert property ((wr_take and s_axi_awaddr_in == 8'h2c &&
    s_axi_wdata_in[0]) |=> ##1 !hpd_out [*8])
    else $error("hot-plug not driven low after pulse write");
  a_soft_rst_pulse: assert property ((wr_take and s_axi_awaddr_in == 8'h1c &&
    s_axi_wdata_in[0]) |-> ##[1:2] video_rst_out)
    else $error("video reset pulse missing");
  a_irq_quiet_reset: assert property ($rose(rst_b_in) |-> !irq_out [*8])
    else $error("interrupt raised under reset mask");
endmodule // dsc_regs_asserts
bind dsc_regs dsc_regs_asserts #(.ADDR_W(ADDR_W), .HPD_LOW_CYCLES(HPD_LOW_CYCLES)) u_chk (.*);

// ==== test/dsc_src_model.sv ====
// behavioural transmitting source on the aux request side
`timescale 1ns/1ps
module dsc_src_model (
  input wire clk_in,
  input wire hpd_in,
  output logic in_prog_out = 0,
  output logic sync_out = 0,
  output logic rise_out = 0,
  output logic done_out = 0,
  output logic err_out = 0,
  output logic [3:0] cmd_out = 4'ha,
  output logic [19:0] addr_out = 20'h5a5a5,
  output logic [3:0] len_out = 4'h5,
  output logic aonly_out = 1'b0
);
  int n;
  int misses = 0;
  task request(input [3:0] c, input [19:0] a, input [3:0] l, input ao, input [9:0] per,
    input er);
    begin
      n = 0;
      while (!hpd_in && n < 100)
      begin
        @(negedge clk_in);
        n++;
      end
      if (!hpd_in)
        misses++;
      in_prog_out = 1;
      sync_out = 1;
      repeat (4)
      begin
        rise_out = 1;
        @(negedge clk_in);
        rise_out = 0;
        repeat (per - 1) @(negedge clk_in);
      end
      sync_out = 0;
      {cmd_out, addr_out, len_out, aonly_out} = {c, a, l, ao};
      done_out = 1;
      err_out = er;
      @(negedge clk_in);
      {done_out, err_out, in_prog_out} = 3'h0;
      {cmd_out, addr_out, len_out, aonly_out} = ~{c, a, l, ao};
      @(negedge clk_in);
    end
  endtask
endmodule // dsc_src_model

// ==== test/dsc_regs_tb.sv ====
// self-checking bench for the sink register bank
`timescale 1ns/1ps
module dsc_regs_tb;
  localparam HPD = 20;
  logic core_clk_in = 0, rst_b_in = 0;
  logic [7:0] s_axi_awaddr_in = 0, s_axi_araddr_in = 0;
  logic [31:0] s_axi_wdata_in = 0;
  logic [3:0] s_axi_wstrb_in = 4'hf;
  logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_arvalid_in = 0;
  logic s_axi_bready_in = 1, s_axi_rready_in = 1;
  logic [2:0] lane_count_in = 3'h4;
  logic ev_ext_pkt_in = 0, ev_info_pkt_in = 0, ev_power_state_in = 0, scrambler_reset_in = 0;
  logic frame_start_in = 0, training_done_in = 0, link_locked_in = 1, vbid_vblank_in = 0;
  logic vbid_novideo_in = 0, active_video_in = 0, msa_valid_in = 0, active_end_in = 0;
  logic [15:0] msa_hres_in = 0, msa_vres_in = 16'h0438;
  wire aux_in_progress_in, aux_sync_in, aux_edge_in, aux_req_done_in, aux_req_err_in;
  wire aux_addr_only_in, s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  wire s_axi_arready_out, s_axi_rvalid_out, hpd_out, aux_tick_out, timing_gen_en_out;
  wire msa_filter_on_out, i2c_defer_long_out, i2c_defer_as_aux_out, video_rst_out;
  wire hsync_out, irq_out;
  wire [3:0] aux_cmd_in, aux_len_in;
  wire [19:0] aux_addr_in;
  wire [1:0] s_axi_bresp_out, s_axi_rresp_out;
  wire [31:0] s_axi_rdata_out;
  wire [2:0] pixel_width_out;
  wire [15:0] msa_hres_out, msa_vres_out;
  wire [7:0] fast_i2c_div_out;
  int failures = 0, checks = 0, n, m, vr_seen = 0, hs_cnt = 0, hpd_lo = 0;
  logic [31:0] expq[$];
  logic [31:0] d;
  logic [7:0] rw_a[8] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h50, 8'h60};
  logic [31:0] rw_m[8] = '{32'h1, 32'hff, 32'h1, 32'h7, 32'h3ff, 32'h7, 32'hffff, 32'hff};
  always #25 core_clk_in = ~core_clk_in;
  dsc_regs #(.HPD_LOW_CYCLES(HPD)) dut (.*);
  dsc_src_model src (.clk_in(core_clk_in), .hpd_in(hpd_out), .in_prog_out(aux_in_progress_in),
    .sync_out(aux_sync_in), .rise_out(aux_edge_in), .done_out(aux_req_done_in),
    .err_out(aux_req_err_in), .cmd_out(aux_cmd_in), .addr_out(aux_addr_in),
    .len_out(aux_len_in), .aonly_out(aux_addr_only_in));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      checks++;
      if (got !== exp)
      begin
        failures++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task complete_run;
    begin
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task wait_ack(input bit rd_sel);
    begin
      n = 0;
      do
      begin
        @(negedge core_clk_in);
        n++;
      end while (!(rd_sel ? s_axi_arready_out : s_axi_awready_out) && n < 20);
      if (!(rd_sel ? s_axi_arready_out : s_axi_awready_out))
      begin
        failures++;
        complete_run;
      end
      @(negedge core_clk_in);
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    begin
      {s_axi_awaddr_in, s_axi_wdata_in, s_axi_awvalid_in, s_axi_wvalid_in} = {a, v, 2'b11};
      wait_ack(0);
      {s_axi_awvalid_in, s_axi_wvalid_in} = 2'b00;
      @(negedge core_clk_in);
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      expq.push_back(e);
      {s_axi_araddr_in, s_axi_arvalid_in} = {a, 1'b1};
      wait_ack(1);
      s_axi_arvalid_in = 0;
      @(negedge core_clk_in);
    end
  endtask
  // one-cycle strobes on the event inputs, then one quiet cycle
  task pulse(input [7:0] sel);
    begin
      {ev_ext_pkt_in, ev_info_pkt_in, ev_power_state_in, scrambler_reset_in, frame_start_in,
        active_video_in, msa_valid_in, active_end_in} = sel;
      @(negedge core_clk_in);
      {ev_ext_pkt_in, ev_info_pkt_in, ev_power_state_in, scrambler_reset_in, frame_start_in,
        active_video_in, msa_valid_in, active_end_in} = 8'h00;
      @(negedge core_clk_in);
    end
  endtask
  always @(posedge core_clk_in)
  begin
    vr_seen += video_rst_out;
    hs_cnt += hsync_out;
    hpd_lo += !hpd_out;
    if (s_axi_rvalid_out && s_axi_rready_in)
      chk(s_axi_rdata_out, expq.size() ? expq.pop_front() : 32'hffffffff);
  end
  initial
  begin
    void'($urandom(32'h9f687b56));
    repeat (4) @(posedge core_clk_in);
    @(negedge core_clk_in);
    rst_b_in = 1;
    @(negedge core_clk_in);
    rd(8'h14, 32'h3ff);
    rd(8'h50, 32'h0f0f);
    rd(8'h10, 32'h4);
    for (int i = 0; i < 8; i++)
    begin
      d = $urandom;
      wr(rw_a[i], d);
      rd(rw_a[i], d & rw_m[i]);
    end
    wr(8'h10, 2);
    chk(pixel_width_out, 2);
    wr(8'h18, 6);
    chk({i2c_defer_as_aux_out, i2c_defer_long_out, msa_filter_on_out}, 6);
    wr(8'h60, 20 / 10 - 1);
    chk(fast_i2c_div_out, 1);
    rd(8'h08, 0);
    wr(8'h08, 1);
    chk(s_axi_bresp_out, 3);
    rd(8'h1c, 0);
    rd(8'h2c, 0);
    wr(8'h04, 5);
    m = 0;
    while (!aux_tick_out && m < 20)
    begin
      @(negedge core_clk_in);
      m++;
    end
    m = 0;
    do
    begin
      @(negedge core_clk_in);
      m++;
    end while (!aux_tick_out && m < 20);
    chk(m, 5);
    vr_seen = 0;
    wr(8'h1c, 1);
    repeat (3) @(negedge core_clk_in);
    chk(vr_seen, 1);
    wr(8'h00, 1);
    chk(hpd_out, 1);
    hpd_lo = 0;
    wr(8'h2c, 1);
    repeat (HPD + 10) @(negedge core_clk_in);
    chk(hpd_lo, HPD);
    chk(hpd_out, 1);
    rd(8'h40, 0);
    wr(8'h14, 0);
    pulse(8'he0);
    chk(irq_out, 1);
    rd(8'h40, 32'h302);
    rd(8'h40, 0);
    chk(irq_out, 0);
    wr(8'h14, 32'h200);
    pulse(8'h80);
    chk(irq_out, 0);
    rd(8'h40, 32'h200);
    wr(8'h14, 0);
    pulse(8'h10);
    repeat (7) pulse(8'h08);
    rd(8'h40, 0);
    pulse(8'h08);
    rd(8'h40, 32'h40);
    link_locked_in = 0;
    pulse(8'h00);
    rd(8'h40, 0);
    {link_locked_in, training_done_in} = 2'b11;
    pulse(8'h00);
    link_locked_in = 0;
    pulse(8'h00);
    rd(8'h40, 32'h10);
    vbid_vblank_in = 1;
    pulse(8'h00);
    rd(8'h40, 32'h08);
    wr(8'h0c, 1);
    wr(8'h50, 32'h0302);
    hs_cnt = 0;
    pulse(8'h01);
    repeat (12) @(negedge core_clk_in);
    chk(hs_cnt, 2);
    pulse(8'h04);
    vbid_novideo_in = 1;
    pulse(8'h00);
    rd(8'h40, 32'h04);
    wr(8'h0c, 0);
    chk(timing_gen_en_out, 0);
    msa_hres_in = 16'h0780;
    pulse(8'h02);
    chk(msa_hres_out, 16'h0780);
    chk(msa_vres_out, 16'h0438);
    rd(8'h40, 32'h01);
    wr(8'h18, 1);
    msa_hres_in = 16'h0500;
    pulse(8'h02);
    chk(msa_hres_out, 16'h0780);
    pulse(8'h02);
    chk(msa_hres_out, 16'h0500);
    src.request(4'h9, 20'h12345, 4'h3, 0, 10'd7, 0);
    rd(8'h30, 7);
    rd(8'h34, 9);
    rd(8'h38, 32'h12345);
    rd(8'h3c, 3);
    rd(8'h28, 1);
    rd(8'h24, 0);
    src.request(4'h1, 20'hfffff, 4'h5, 1, 10'd4, 1);
    rd(8'h38, 32'h7f);
    rd(8'h3c, 0);
    rd(8'h28, 2);
    rd(8'h24, 1);
    wr(8'h28, 0);
    rd(8'h28, 0);
    rd(8'h24, 0);
    rd(8'h20, 0);
    chk(src.misses, 0);
    complete_run;
  end
endmodule // dsc_regs_tb
